// >>> tcp_test_user_registers.sv
// Test register bank with a transmit pattern generator and a
// receive pattern checker beside an offload core.
// Assumes the core FIFOs run on pclk; the receive FIFO shows
// read data one cycle after its read enable.
//
// The APB register port was decided locally.
`timescale 1ns/10ps
module tcp_test_user_registers (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [15:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic                          pready,
  output logic [31:0]                   prdata,
  output logic                          pslverr,
  input  wire logic                     connection_open,
  input  wire logic                     offload_timer_interrupt,
  input  wire logic [3:0]               rx_fifo_last_byte_count,
  input  wire logic                     tx_fifo_full,
  output logic                          tx_fifo_write_enable,
  output logic [127:0]                  tx_fifo_write_data,
  input  wire logic                     rx_fifo_empty,
  output logic                          rx_fifo_read_enable,
  input  wire logic [127:0]             rx_fifo_read_data,
  output logic                          irq
);

  // ----------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------
  // Four copies of the 32-bit word count form one 128-bit word
  function automatic logic [127:0] pattern(input logic [31:0] c);
    return {c, c, c, c};
  endfunction

  logic                 pready_r;
  logic [31:0]          prdata_r;
  logic                 pslverr_r;
  logic                 pready_nxt;
  logic [31:0]          prdata_nxt;
  logic                 pslverr_nxt;
  logic [31:0]          tx_size_r;
  logic [31:0]          tx_size_nxt;
  logic                 verify_en_r;
  logic                 verify_en_nxt;
  logic                 soft_rst_r;
  logic                 soft_rst_nxt;
  test_regs_pkg::tx_state_t tx_st_r;
  test_regs_pkg::tx_state_t tx_st_nxt;
  logic [31:0]          tx_cnt_r;
  logic [31:0]          tx_cnt_nxt;
  logic                 rd_d_r;
  logic                 rd_d_nxt;
  logic [31:0]          rx_cnt_r;
  logic [31:0]          rx_cnt_nxt;
  logic                 fail_r;
  logic                 fail_nxt;
  logic                 timer_seen_r;
  logic                 timer_seen_nxt;
  test_regs_pkg::irq_bits_t sts_r;
  test_regs_pkg::irq_bits_t sts_nxt;
  test_regs_pkg::irq_bits_t mask_r;
  test_regs_pkg::irq_bits_t mask_nxt;
  logic                 irq_r;
  logic                 irq_nxt;
  logic                 setup;
  logic                 wr_acc;
  logic                 wr_tx_len;
  logic                 wr_cmd;
  logic                 wr_rst;
  logic                 start;
  logic                 mismatch;
  logic                 done_ev;

  // ----------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------
  // Zero-wait slave: a write lands at the access edge
  assign setup     = psel & ~penable;
  assign wr_acc    = psel & penable & pwrite & pready_r;
  assign wr_tx_len = wr_acc & (paddr == test_regs_pkg::OFF_TX_LEN);
  assign wr_cmd    = wr_acc & (paddr == test_regs_pkg::OFF_CMD);
  assign wr_rst    = wr_acc & (paddr == test_regs_pkg::OFF_RST);
  // A zero size would never finish, so it is refused
  assign start = wr_cmd & ~pwdata[test_regs_pkg::CMD_START_N]
                 & (tx_size_r != test_regs_pkg::COUNT_RST);

  // Write gating must react in the same cycle as full, so these
  // two strobes are gates on tx_fifo_full and rx_fifo_empty, not flops
  assign tx_fifo_write_enable = (tx_st_r == test_regs_pkg::TX_RUN)
                                & ~tx_fifo_full;
  assign tx_fifo_write_data   = pattern(tx_cnt_r);
  assign rx_fifo_read_enable  = ~rx_fifo_empty;
  assign mismatch = rd_d_r & verify_en_r
                    & (rx_fifo_read_data != pattern(rx_cnt_r));
  assign pready  = pready_r;
  assign prdata  = prdata_r;
  assign pslverr = pslverr_r;
  assign irq     = irq_r;

  // ----------------------------------------------------------
  // Read path
  // ----------------------------------------------------------
  // Read data is captured in setup so it is stable in access
  always_comb begin
    pready_nxt  = 1'b1;
    prdata_nxt  = prdata_r;
    pslverr_nxt = pslverr_r;
    if (setup) begin
      prdata_nxt  = 32'h00000000;
      pslverr_nxt = 1'b0;
      unique case (paddr)
        test_regs_pkg::OFF_TX_LEN: begin
          prdata_nxt = tx_cnt_r;
        end
        test_regs_pkg::OFF_CMD: begin
          prdata_nxt[test_regs_pkg::CMD_BUSY] =
            (tx_st_r == test_regs_pkg::TX_RUN);
          prdata_nxt[test_regs_pkg::CMD_FAIL] = fail_r;
          prdata_nxt[test_regs_pkg::CMD_CONN] =
            connection_open;
        end
        test_regs_pkg::OFF_RST: begin
          prdata_nxt[test_regs_pkg::RST_SOFT]  = soft_rst_r;
          prdata_nxt[test_regs_pkg::RST_TIMER] =
            timer_seen_r;
        end
        test_regs_pkg::OFF_FIFO: begin
          prdata_nxt[test_regs_pkg::FF_LAST_LSB +: test_regs_pkg::FF_LAST_W]
            = rx_fifo_last_byte_count;
          prdata_nxt[test_regs_pkg::FF_TX_FULL] =
            tx_fifo_full;
        end
        test_regs_pkg::OFF_RX_LEN: begin
          prdata_nxt = rx_cnt_r;
        end
        test_regs_pkg::OFF_IRQ_STS: begin
          prdata_nxt[test_regs_pkg::IRQ_W-1:0] = sts_r;
        end
        test_regs_pkg::OFF_IRQ_MASK: begin
          prdata_nxt[test_regs_pkg::IRQ_W-1:0] = mask_r;
        end
        default: begin
          pslverr_nxt = 1'b1;
        end
      endcase
      // Unmapped writes are refused the same way
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= pready_nxt;
      prdata_r  <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // ----------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------
  // Soft reset is a one-cycle pulse that clears the test logic
  always_comb begin
    tx_size_nxt   = tx_size_r;
    verify_en_nxt = verify_en_r;
    soft_rst_nxt  = wr_rst & pwdata[test_regs_pkg::RST_SOFT];
    if (soft_rst_r) begin
      tx_size_nxt   = test_regs_pkg::TX_SIZE_RST;
      verify_en_nxt = 1'b0;
    end else begin
      if (wr_tx_len) begin
        tx_size_nxt = pwdata;
      end
      if (wr_cmd) begin
        verify_en_nxt = pwdata[test_regs_pkg::CMD_VERIFY];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_size_r   <= test_regs_pkg::TX_SIZE_RST;
      verify_en_r <= 1'b0;
      soft_rst_r  <= 1'b0;
    end else begin
      tx_size_r   <= tx_size_nxt;
      verify_en_r <= verify_en_nxt;
      soft_rst_r  <= soft_rst_nxt;
    end
  end

  // ----------------------------------------------------------
  // Pattern generator and checker
  // ----------------------------------------------------------
  // A command write with bit 0 high stops a running transfer
  always_comb begin
    tx_st_nxt  = tx_st_r;
    tx_cnt_nxt = tx_cnt_r;
    done_ev    = 1'b0;
    rd_d_nxt   = rx_fifo_read_enable & ~soft_rst_r;
    rx_cnt_nxt = rx_cnt_r;
    fail_nxt   = fail_r;
    if (soft_rst_r) begin
      tx_st_nxt  = test_regs_pkg::TX_IDLE;
      tx_cnt_nxt = test_regs_pkg::COUNT_RST;
      rx_cnt_nxt = test_regs_pkg::COUNT_RST;
      fail_nxt   = 1'b0;
    end else begin
      if (wr_cmd) begin
        tx_cnt_nxt = test_regs_pkg::COUNT_RST;
        rx_cnt_nxt = test_regs_pkg::COUNT_RST;
        fail_nxt   = 1'b0;
        tx_st_nxt  = start ? test_regs_pkg::TX_RUN
                           : test_regs_pkg::TX_IDLE;
      end else begin
        if (tx_fifo_write_enable) begin
          tx_cnt_nxt = tx_cnt_r + test_regs_pkg::ONE32;
          if (tx_cnt_nxt == tx_size_r) begin
            tx_st_nxt = test_regs_pkg::TX_IDLE;
            done_ev   = 1'b1;
          end
        end
        if (rd_d_r) begin
          rx_cnt_nxt = rx_cnt_r + test_regs_pkg::ONE32;
        end
      end
      // A mismatch in the clearing cycle still sets the flag
      if (mismatch) begin
        fail_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_r  <= test_regs_pkg::TX_IDLE;
      tx_cnt_r <= test_regs_pkg::COUNT_RST;
      rd_d_r   <= 1'b0;
      rx_cnt_r <= test_regs_pkg::COUNT_RST;
      fail_r   <= 1'b0;
    end else begin
      tx_st_r  <= tx_st_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      rd_d_r   <= rd_d_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      fail_r   <= fail_nxt;
    end
  end

  // ----------------------------------------------------------
  // Timer latch and interrupts
  // ----------------------------------------------------------
  // Set beats clear everywhere so no event is lost
  always_comb begin
    timer_seen_nxt = timer_seen_r;
    if (wr_rst && pwdata[test_regs_pkg::RST_TIMER]) begin
      timer_seen_nxt = 1'b0;
    end
    if (offload_timer_interrupt) begin
      timer_seen_nxt = 1'b1;
    end
    sts_nxt  = sts_r;
    mask_nxt = mask_r;
    if (wr_acc && paddr == test_regs_pkg::OFF_IRQ_STS) begin
      sts_nxt = sts_r & ~pwdata[test_regs_pkg::IRQ_W-1:0];
    end
    if (wr_acc && paddr == test_regs_pkg::OFF_IRQ_MASK) begin
      mask_nxt = pwdata[test_regs_pkg::IRQ_W-1:0];
    end
    sts_nxt.done  = sts_nxt.done  | done_ev;
    sts_nxt.fail  = sts_nxt.fail  | mismatch;
    sts_nxt.timer = sts_nxt.timer | offload_timer_interrupt;
    irq_nxt = |(sts_nxt & mask_nxt);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_seen_r <= 1'b0;
      sts_r        <= test_regs_pkg::IRQ_RST;
      mask_r       <= test_regs_pkg::IRQ_RST;
      irq_r        <= 1'b0;
    end else begin
      timer_seen_r <= timer_seen_nxt;
      sts_r        <= sts_nxt;
      mask_r       <= mask_nxt;
      irq_r        <= irq_nxt;
    end
  end

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_full_gates_write: assert property (
    tx_fifo_full |-> !tx_fifo_write_enable)
    else $error("write while transmit FIFO full");
  a_cmd_clears_count: assert property (
    wr_cmd |=> tx_cnt_r == 32'h00000000)
    else $error("command write did not clear count");
  a_start_runs: assert property (
    start && !soft_rst_r |=> tx_st_r == test_regs_pkg::TX_RUN)
    else $error("start did not begin a run");
  a_tx_count_step: assert property (
    tx_fifo_write_enable && !wr_cmd && !soft_rst_r
    |=> tx_cnt_r == $past(tx_cnt_r) + 32'h00000001)
    else $error("sent count did not advance");
  a_run_ends: assert property (
    tx_fifo_write_enable && !wr_cmd && !soft_rst_r
    && tx_cnt_r + 32'h00000001 == tx_size_r
    |=> tx_st_r == test_regs_pkg::TX_IDLE && !tx_fifo_write_enable)
    else $error("run did not end at size");
  a_rd_pipe: assert property (
    !rx_fifo_empty && !soft_rst_r |=> rd_d_r)
    else $error("delayed read enable missing");
  a_fail_sets: assert property (
    mismatch && !soft_rst_r |=> fail_r ##1 (fail_r || $past(wr_cmd)
    || $past(soft_rst_r)))
    else $error("mismatch not flagged");
  a_verify_off: assert property (
    !verify_en_r && !fail_r && !wr_cmd |=> !fail_r)
    else $error("flag set with checking off");
  a_timer_latch: assert property (
    offload_timer_interrupt |=> timer_seen_r)
    else $error("timer interrupt not latched");
  a_timer_clear: assert property (
    wr_rst && pwdata[8] && !offload_timer_interrupt |=> !timer_seen_r)
    else $error("timer flag not cleared");
  a_soft_reset: assert property (
    wr_rst && pwdata[0] |=> soft_rst_r ##1
    (tx_st_r == test_regs_pkg::TX_IDLE && rx_cnt_r == 32'h00000000))
    else $error("soft reset did not clear logic");
  a_conn_read: assert property (
    setup && !pwrite && paddr == test_regs_pkg::OFF_CMD
    |=> prdata[2] == $past(connection_open))
    else $error("connection bit wrong");
  a_fifo_read: assert property (
    setup && !pwrite && paddr == test_regs_pkg::OFF_FIFO
    |=> prdata[3:0] == $past(rx_fifo_last_byte_count)
    && prdata[24] == $past(tx_fifo_full))
    else $error("FIFO state read wrong");
  a_irq_level: assert property (
    irq == |(sts_r & mask_r))
    else $error("interrupt level wrong");

  c_run_done: cover property (done_ev);
  c_mismatch: cover property (mismatch);
  c_timer:    cover property (wr_rst && timer_seen_r);
  c_stall:    cover property (tx_st_r == test_regs_pkg::TX_RUN
                              && tx_fifo_full);

endmodule

// >>> test_regs_pkg.sv
// Constants and types shared by the test register block.
// Assumes a 32-bit APB bus and a 16-bit byte address window.
package test_regs_pkg;

  // ----------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------
  localparam int          ADDR_W       = 16;
  localparam logic [15:0] OFF_TX_LEN   = 16'h1000;
  localparam logic [15:0] OFF_CMD      = 16'h1004;
  localparam logic [15:0] OFF_RST      = 16'h1008;
  localparam logic [15:0] OFF_FIFO     = 16'h100C;
  localparam logic [15:0] OFF_RX_LEN   = 16'h1010;
  localparam logic [15:0] OFF_IRQ_STS  = 16'h1014;
  localparam logic [15:0] OFF_IRQ_MASK = 16'h1018;

  // ----------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------
  localparam int CMD_START_N  = 0;
  localparam int CMD_VERIFY   = 1;
  localparam int CMD_BUSY     = 0;
  localparam int CMD_FAIL     = 1;
  localparam int CMD_CONN     = 2;
  localparam int RST_SOFT     = 0;
  localparam int RST_TIMER    = 8;
  localparam int FF_LAST_LSB  = 0;
  localparam int FF_LAST_W    = 4;
  localparam int FF_TX_FULL   = 24;
  localparam int IRQ_W        = 3;

  // ----------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------
  localparam logic [31:0] TX_SIZE_RST = 32'h00000000;
  localparam logic [31:0] TX_SIZE_MAX = 32'h0FFFFFFF;
  localparam logic [31:0] COUNT_RST   = 32'h00000000;
  localparam logic [31:0] ONE32       = 32'h00000001;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

  // Sticky event bits, same layout in status and mask
  typedef struct packed {
    logic timer;
    logic fail;
    logic done;
  } irq_bits_t;

  typedef enum logic {TX_IDLE, TX_RUN} tx_state_t;

endpackage

// >>> offload_fifo_model.sv
// Behavioural model of the offload core transmit and receive FIFOs.
// Assumes one clock shared with the register block.
`timescale 1ns/10ps
module offload_fifo_model (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         restart,
  input  wire logic         stall_tx,
  input  wire logic [31:0]  rx_avail,
  input  wire logic [31:0]  bad_index,
  input  wire logic         tx_fifo_write_enable,
  input  wire logic [127:0] tx_fifo_write_data,
  output logic              tx_fifo_full,
  input  wire logic         rx_fifo_read_enable,
  output logic              rx_fifo_empty,
  output logic [127:0]      rx_fifo_read_data,
  output logic [31:0]       tx_seen,
  output logic              tx_ok
);
  logic [31:0] served;

  // Full is commanded by the bench to stall the generator
  assign tx_fifo_full  = stall_tx;
  assign rx_fifo_empty = (served >= rx_avail);

  // ----------------------------------------------------------
  // Receive side serves a counted pattern, transmit side checks
  // ----------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      served            <= 32'h0;
      tx_seen           <= 32'h0;
      tx_ok             <= 1'b1;
      rx_fifo_read_data <= '1;
    end else begin
      // Data valid one cycle after a read, else it toggles
      if (rx_fifo_read_enable && !rx_fifo_empty) begin
        rx_fifo_read_data <= {4{served}} ^ {127'h0, served == bad_index};
        served            <= served + 32'h1;
      end else begin
        rx_fifo_read_data <= ~rx_fifo_read_data;
      end
      if (tx_fifo_write_enable) begin
        if (tx_fifo_full || tx_fifo_write_data !== {4{tx_seen}}) begin
          tx_ok <= 1'b0;
        end
        tx_seen <= tx_seen + 32'h1;
      end
      if (restart) begin
        served  <= 32'h0;
        tx_seen <= 32'h0;
      end
    end
  end
endmodule

// >>> tcp_test_user_registers_bench.sv
// Self-checking bench of the test register block over APB.
// Assumes the FIFO model stands in for the offload core.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  bad_count++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tcp_test_user_registers_bench;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [15:0]  paddr;
  logic [31:0]  pwdata, prdata, rx_avail, bad_index, tx_seen, q;
  logic         connection_open, offload_timer_interrupt, tx_fifo_full;
  logic [3:0]   rx_fifo_last_byte_count;
  logic         tx_fifo_write_enable, rx_fifo_empty, rx_fifo_read_enable;
  logic [127:0] tx_fifo_write_data, rx_fifo_read_data;
  logic         irq, restart, stall_tx, tx_ok, err;
  int           bad_count, samples_checked;

  tcp_test_user_registers u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .connection_open(connection_open),
    .offload_timer_interrupt(offload_timer_interrupt),
    .rx_fifo_last_byte_count(rx_fifo_last_byte_count),
    .tx_fifo_full(tx_fifo_full),
    .tx_fifo_write_enable(tx_fifo_write_enable),
    .tx_fifo_write_data(tx_fifo_write_data),
    .rx_fifo_empty(rx_fifo_empty),
    .rx_fifo_read_enable(rx_fifo_read_enable),
    .rx_fifo_read_data(rx_fifo_read_data), .irq(irq));

  offload_fifo_model u_core (
    .pclk(pclk), .presetn(presetn), .restart(restart),
    .stall_tx(stall_tx), .rx_avail(rx_avail), .bad_index(bad_index),
    .tx_fifo_write_enable(tx_fifo_write_enable),
    .tx_fifo_write_data(tx_fifo_write_data),
    .tx_fifo_full(tx_fifo_full), .rx_fifo_empty(rx_fifo_empty),
    .rx_fifo_read_enable(rx_fifo_read_enable),
    .rx_fifo_read_data(rx_fifo_read_data), .tx_seen(tx_seen),
    .tx_ok(tx_ok));

  // ----------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------
  // One APB transfer; idles a cycle after so no signal is set twice
  task automatic apb(input logic wr, input logic [15:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Waits as long as the slave stalls; only the watchdog ends it
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q       = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] e,
                    input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, q)
  endtask

  // Reads until the masked field matches, bounded by forty reads
  task automatic poll(input logic [15:0] a, input logic [31:0] m,
                      input logic [31:0] e, input string nm);
    for (int i = 0; i < 40; i++) begin
      apb(1'b0, a, 32'h0);
      if ((q & m) === e) break;
    end
    `CHK(nm, e, q & m)
  endtask

  // Clears the model's counts together with a command write
  task automatic fresh(input logic [31:0] cmd);
    restart <= 1'b1;
    @(posedge pclk);
    restart <= 1'b0;
    wr(test_regs_pkg::OFF_CMD, cmd);
  endtask

  task automatic rx_run(input logic [31:0] cmd, input logic [31:0] n,
                        input logic [31:0] bad);
    rx_avail <= 32'h0;
    @(posedge pclk);
    fresh(cmd);
    bad_index <= bad;
    rx_avail  <= n;
    poll(test_regs_pkg::OFF_RX_LEN, '1, n, "rx_len");
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------
  // Clock, watchdog and test sequence
  // ----------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Whole run needs under two hundred cycles
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    end_sim();
  end

  initial begin
    {presetn, psel, penable, pwrite, restart} = 5'h0;
    {paddr, pwdata, bad_index, rx_avail} = '0;
    {connection_open, offload_timer_interrupt, stall_tx} = 3'h0;
    rx_fifo_last_byte_count = 4'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(test_regs_pkg::OFF_TX_LEN, 32'h0, "tx_len_rst");
    rd(test_regs_pkg::OFF_RX_LEN, 32'h0, "rx_len_rst");
    rd(16'h1020, 32'h0, "unmapped");
    `CHK("unmapped_err", 1'b1, err)
    // Live mirrors of core status
    rx_fifo_last_byte_count <= 4'hA;
    stall_tx                <= 1'b1;
    connection_open         <= 1'b1;
    rd(test_regs_pkg::OFF_FIFO, 32'h0100000A, "fifo");
    rd(test_regs_pkg::OFF_CMD, 32'h4, "conn_on");
    connection_open <= 1'b0;
    rd(test_regs_pkg::OFF_CMD, 32'h0, "conn_off");
    // Transmit run that starts stalled
    wr(test_regs_pkg::OFF_TX_LEN, 32'h5);
    wr(test_regs_pkg::OFF_CMD, 32'h0);
    rd(test_regs_pkg::OFF_CMD, 32'h1, "busy");
    rd(test_regs_pkg::OFF_TX_LEN, 32'h0, "stalled");
    stall_tx <= 1'b0;
    poll(test_regs_pkg::OFF_CMD, 32'h1, 32'h0, "idle");
    rd(test_regs_pkg::OFF_TX_LEN, 32'h5, "tx_len");
    `CHK("tx_words", 32'h5, tx_seen)
    `CHK("tx_data", 1'b1, tx_ok)
    rd(test_regs_pkg::OFF_IRQ_STS, 32'h1, "irq_sts");
    wr(test_regs_pkg::OFF_IRQ_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    `CHK("irq_on", 1'b1, irq)
    wr(test_regs_pkg::OFF_IRQ_STS, 32'h1);
    repeat (2) @(posedge pclk);
    `CHK("irq_off", 1'b0, irq)
    // Receive with and without comparison
    rx_run(32'h3, 32'h4, '1);
    rd(test_regs_pkg::OFF_TX_LEN, 32'h0, "tx_clr");
    rd(test_regs_pkg::OFF_CMD, 32'h0, "clean");
    rx_run(32'h3, 32'h4, 32'h2);
    rd(test_regs_pkg::OFF_CMD, 32'h2, "fail");
    rx_run(32'h1, 32'h3, 32'h1);
    rd(test_regs_pkg::OFF_CMD, 32'h0, "no_fail");
    // Timer latch and its clear
    offload_timer_interrupt <= 1'b1;
    @(posedge pclk);
    offload_timer_interrupt <= 1'b0;
    rd(test_regs_pkg::OFF_RST, 32'h100, "timer");
    wr(test_regs_pkg::OFF_RST, 32'h100);
    rd(test_regs_pkg::OFF_RST, 32'h0, "timer_clr");
    // Soft reset in mid-run also drops the size
    wr(test_regs_pkg::OFF_TX_LEN, 32'h64);
    fresh(32'h0);
    wr(test_regs_pkg::OFF_RST, 32'h1);
    poll(test_regs_pkg::OFF_CMD, 32'h1, 32'h0, "soft");
    rd(test_regs_pkg::OFF_TX_LEN, 32'h0, "soft_cnt");
    rd(test_regs_pkg::OFF_RST, 32'h0, "soft_bit");
    wr(test_regs_pkg::OFF_CMD, 32'h0);
    rd(test_regs_pkg::OFF_CMD, 32'h0, "size0");
    `CHK("tx_data2", 1'b1, tx_ok)
    end_sim();
  end
endmodule
